// *** hdl/scmc_clock_mode_ctrl.sv ***
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "scmc_defs.svh"

module scmc_clock_mode_ctrl
    import scmc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic haltReq,
    input wire logic wakeReq,
    input wire logic subTick,
    input wire logic voltageDetectEnable,
    input wire logic watchdogEnable,
    input wire logic lowVoltageEvent,
    input wire logic brownoutLevelBad,
    input wire logic watchdogCtrlReset,
    output logic sysClkTick,
    output logic cpuRun,
    output logic fastOscEnable,
    output logic subclkEnable,
    output logic slowSrcCrystal,
    output logic slowLowPower,
    output logic watchdogRun,
    output logic detectorKeep,
    output logic periphEnable,
    output logic subcodeResetReq,
    output logic brownoutSwReset,
    output logic irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic isSub(input logic [3:0] sel);
        return !sel[3] && (sel[2:1] == 2'b00);
    endfunction : isSub

    function automatic logic tickOf(input logic [3:0] sel,
                                    input logic [5:0] cnt,
                                    input logic fastOk,
                                    input logic subOk,
                                    input logic sub);
        logic [5:0] mask;
        mask = 6'h00;
        case (sel[2:0])
            3'b010: mask = 6'h3f;
            3'b011: mask = 6'h1f;
            3'b100: mask = 6'h0f;
            3'b101: mask = 6'h07;
            3'b110: mask = 6'h03;
            default: mask = 6'h01;
        endcase
        if (sel[3]) begin
            return fastOk;
        end else if (isSub(sel)) begin
            return sub && subOk;
        end
        return fastOk && ((cnt & mask) == mask);
    endfunction : tickOf

    // ----------------------------------------
    // State
    // ----------------------------------------
    scmc_mode_e state_r, stateNxt;
    logic fastSel_r, idleSel_r, keep_r, subLowPwr_r;
    logic [2:0] div_r;
    logic [6:0] subCode_r;
    logic [3:0] curSel_r;
    logic [5:0] divCnt_r;
    logic [4:0] fastCnt_r;
    logic [10:0] slowCnt_r;
    logic fastRdy_r, slowRdy_r;
    logic subfFlag_r, borFlag_r, lrfFlag_r, wrfFlag_r;
    logic [3:0] stat_r, mask_r;
    logic [7:0] rdata_r;
    logic tick_r, cpuRun_r, fastEn_r, subEn_r, wdtRun_r, detKeep_r;
    logic periph_r, subRst_r, borRst_r, irq_r, xtal_r;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic wrMode = regWr && (regAddr == `SCMC_ADDR_MODE);
    wire logic wrCtrl = regWr && (regAddr == `SCMC_ADDR_CTRL);
    wire logic wrSub = regWr && (regAddr == `SCMC_ADDR_SUBSEL);
    wire logic wrStat = regWr && (regAddr == `SCMC_ADDR_STAT);
    wire logic wrMask = regWr && (regAddr == `SCMC_ADDR_MASK);
    wire logic [3:0] targetSel = {fastSel_r, div_r};
    wire logic codeRc = (subCode_r == `SCMC_SUB_RC);
    wire logic codeXtal = (subCode_r == `SCMC_SUB_XTAL);
    wire logic codeBad = !codeRc && !codeXtal;
    wire logic running = (state_r == ST_RUN);
    wire logic curFast = !isSub(curSel_r);
    wire logic tgtFast = !isSub(targetSel);
    wire logic curTick = tickOf(curSel_r, divCnt_r, fastRdy_r, slowRdy_r,
                                subTick);
    wire logic curDead = curFast ? !fastRdy_r : !slowRdy_r;
    wire logic tgtReady = tgtFast ? fastRdy_r : slowRdy_r;
    wire logic doSwitch = running && (targetSel != curSel_r) && tgtReady
                          && (curTick || curDead);
    wire logic [3:0] curSelNxt = doSwitch ? targetSel : curSel_r;
    wire logic [10:0] slowLimit = codeXtal ? 11'(`SCMC_SLOW_XTAL_TICKS)
                                           : 11'(`SCMC_SLOW_RC_TICKS);
    wire logic [7:0] modeRead = {div_r, 1'b0, slowRdy_r, fastRdy_r,
                                 idleSel_r, fastSel_r};
    wire logic [7:0] ctrlRead = {keep_r, 3'b000, subfFlag_r, borFlag_r,
                                 lrfFlag_r, wrfFlag_r};
    wire logic [3:0] statSet = {subfFlag_r | borFlag_r | lrfFlag_r |
                                wrfFlag_r,
                                running && (state_r != stateNxt) ? 1'b0
                                    : (!running && stateNxt == ST_RUN),
                                slowCnt_r == slowLimit - 11'd1 && subTick
                                    && subEn_r && !slowRdy_r,
                                fastCnt_r == 5'(`SCMC_FAST_READY_CYCLES - 1)
                                    && fastEn_r};
    wire logic [3:0] statNxt = statSet |
                               (stat_r & ~(wrStat ? regWdata[3:0] : 4'h0));
    wire logic [3:0] maskNxt = wrMask ? regWdata[3:0] : mask_r;

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (haltReq) begin
                    if (idleSel_r) begin
                        stateNxt = keep_r ? ST_IDLE_RUNNING
                                          : ST_IDLE_STOPPED;
                    end else if (voltageDetectEnable || watchdogEnable) begin
                        stateNxt = ST_LIGHT_SLEEP;
                    end else begin
                        stateNxt = ST_DEEP_SLEEP;
                    end
                end
            end
            default: begin
                if (wakeReq) begin
                    stateNxt = ST_RUN;
                end
            end
        endcase
    end

    wire logic deepNxt = (stateNxt == ST_DEEP_SLEEP);
    wire logic sleepNxt = deepNxt || (stateNxt == ST_LIGHT_SLEEP);
    wire logic runNxt = (stateNxt == ST_RUN);
    wire logic idleRunNxt = (stateNxt == ST_IDLE_RUNNING);
    wire logic fastEnNxt = (runNxt && (!isSub(curSelNxt) || tgtFast))
                           || (idleRunNxt && !isSub(curSelNxt));
    wire logic subEnNxt = !deepNxt || voltageDetectEnable;
    wire logic tickNxt = (running || state_r == ST_IDLE_RUNNING)
                         && (runNxt || idleRunNxt) && curTick;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= stateNxt;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fastSel_r <= 1'(`SCMC_MODE_RST >> `SCMC_MODE_FASTSEL);
            idleSel_r <= 1'(`SCMC_MODE_RST >> `SCMC_MODE_IDLESEL);
            div_r <= 3'(`SCMC_MODE_RST >> `SCMC_MODE_DIV_LO);
            keep_r <= 1'b0;
            subCode_r <= 7'(`SCMC_SUB_RST);
            subLowPwr_r <= 1'b0;
            mask_r <= 4'h0;
        end else begin
            if (wrMode) begin
                fastSel_r <= regWdata[`SCMC_MODE_FASTSEL];
                idleSel_r <= regWdata[`SCMC_MODE_IDLESEL];
                div_r <= regWdata[7:`SCMC_MODE_DIV_LO];
            end
            if (wrCtrl) begin
                keep_r <= regWdata[`SCMC_CTRL_KEEP];
            end
            if (wrSub) begin
                subCode_r <= regWdata[6:0];
                subLowPwr_r <= regWdata[`SCMC_SUB_LOWPWR];
            end
            mask_r <= maskNxt;
        end
    end

    // ----------------------------------------
    // Reset cause flags, set wins over clear
    // ----------------------------------------
    wire logic clrSubf = wrCtrl && !regWdata[`SCMC_CTRL_SUBF];
    wire logic clrBor = wrCtrl && !regWdata[`SCMC_CTRL_BOR];
    wire logic clrLrf = wrCtrl && !regWdata[`SCMC_CTRL_LRF];
    wire logic clrWrf = wrCtrl && !regWdata[`SCMC_CTRL_WDT];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            subfFlag_r <= 1'b0;
            borFlag_r <= 1'b0;
            lrfFlag_r <= 1'b0;
            wrfFlag_r <= 1'b0;
        end else begin
            subfFlag_r <= codeBad || (subfFlag_r && !clrSubf);
            borFlag_r <= lowVoltageEvent || (borFlag_r && !clrBor);
            lrfFlag_r <= brownoutLevelBad || (lrfFlag_r && !clrLrf);
            wrfFlag_r <= watchdogCtrlReset
                         || (wrfFlag_r && !clrWrf);
        end
    end

    // ----------------------------------------
    // Clock selection and divider
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            curSel_r <= 4'(`SCMC_MODE_RST >> `SCMC_MODE_FASTSEL) << 3;
            divCnt_r <= 6'h00;
        end else begin
            curSel_r <= curSelNxt;
            divCnt_r <= fastRdy_r ? divCnt_r + 6'h01 : 6'h00;
        end
    end

    // ----------------------------------------
    // Oscillator ready tracking
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fastCnt_r <= 5'h00;
            fastRdy_r <= 1'b0;
        end else if (!fastEn_r) begin
            fastCnt_r <= 5'h00;
            fastRdy_r <= 1'b0;
        end else if (!fastRdy_r) begin
            fastCnt_r <= fastCnt_r + 5'h01;
            fastRdy_r <= fastCnt_r == 5'(`SCMC_FAST_READY_CYCLES - 1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slowCnt_r <= 11'h000;
            slowRdy_r <= 1'b0;
        end else if (!subEn_r) begin
            slowCnt_r <= 11'h000;
            slowRdy_r <= 1'b0;
        end else if (!slowRdy_r && subTick) begin
            slowCnt_r <= slowCnt_r + 11'h001;
            slowRdy_r <= slowCnt_r == slowLimit - 11'h001;
        end
    end

    // ----------------------------------------
    // Outputs and read port
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_r <= 1'b0;
            cpuRun_r <= 1'b1;
            fastEn_r <= 1'b1;
            subEn_r <= 1'b1;
            wdtRun_r <= 1'b0;
            detKeep_r <= 1'b0;
            periph_r <= 1'b1;
            subRst_r <= 1'b0;
            borRst_r <= 1'b0;
            xtal_r <= 1'b0;
            stat_r <= 4'h0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            tick_r <= tickNxt;
            cpuRun_r <= runNxt;
            fastEn_r <= fastEnNxt;
            subEn_r <= subEnNxt;
            wdtRun_r <= watchdogEnable && !deepNxt;
            detKeep_r <= voltageDetectEnable;
            periph_r <= !sleepNxt;
            subRst_r <= codeBad;
            borRst_r <= brownoutLevelBad;
            xtal_r <= codeXtal;
            stat_r <= statNxt;
            irq_r <= |(statNxt & maskNxt);
            if (!regRd) begin
                rdata_r <= 8'h00;
            end else if (regAddr == `SCMC_ADDR_MODE) begin
                rdata_r <= modeRead;
            end else if (regAddr == `SCMC_ADDR_CTRL) begin
                rdata_r <= ctrlRead;
            end else if (regAddr == `SCMC_ADDR_SUBSEL) begin
                rdata_r <= {subLowPwr_r, subCode_r};
            end else if (regAddr == `SCMC_ADDR_STAT) begin
                rdata_r <= {4'h0, stat_r};
            end else if (regAddr == `SCMC_ADDR_MASK) begin
                rdata_r <= {4'h0, mask_r};
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign regRdata = rdata_r;
    assign sysClkTick = tick_r;
    assign cpuRun = cpuRun_r;
    assign fastOscEnable = fastEn_r;
    assign subclkEnable = subEn_r;
    assign slowSrcCrystal = xtal_r;
    assign slowLowPower = subLowPwr_r;
    assign watchdogRun = wdtRun_r;
    assign detectorKeep = detKeep_r;
    assign periphEnable = periph_r;
    assign subcodeResetReq = subRst_r;
    assign brownoutSwReset = borRst_r;
    assign irq = irq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_fast_clock_tick: assert property (
        (running && haltReq == 1'b0 && curSel_r[3] && fastRdy_r)
        |=> sysClkTick)
        else $error("fast clock selected but no tick");
    chk_sub_no_tick: assert property (
        (running && isSub(curSel_r) && !subTick) |=> !sysClkTick)
        else $error("subclock selected, tick without source");
    chk_bad_code_reset: assert property (
        codeBad |=> subcodeResetReq && subfFlag_r)
        else $error("bad subclock code gave no reset");
    chk_fast_osc_stop: assert property (
        (running && !haltReq && isSub(curSel_r) && isSub(targetSel))
        |=> !fastOscEnable)
        else $error("fast oscillator left running on subclock");
    chk_deep_sleep_entry: assert property (
        (running && haltReq && !idleSel_r && !voltageDetectEnable
         && !watchdogEnable)
        |=> (state_r == ST_DEEP_SLEEP) && !cpuRun && !watchdogRun
            && !subclkEnable)
        else $error("deep sleep not entered");
    chk_detect_blocks_deep: assert property (
        (running && haltReq && !idleSel_r && voltageDetectEnable)
        |=> (state_r == ST_LIGHT_SLEEP) && subclkEnable && !cpuRun)
        else $error("deep sleep entered with detector on");
    chk_idle_entry: assert property (
        (running && haltReq && idleSel_r)
        |=> !cpuRun && subclkEnable && (state_r ==
            (keep_r ? ST_IDLE_RUNNING : ST_IDLE_STOPPED)))
        else $error("idle mode entry wrong");
    chk_idle_stop_osc: assert property (
        (state_r == ST_IDLE_STOPPED) ##1 (state_r == ST_IDLE_STOPPED)
        |-> !fastOscEnable && !sysClkTick)
        else $error("oscillator running in idle stopped");
    chk_deep_slow_low: assert property (
        (state_r == ST_DEEP_SLEEP && !voltageDetectEnable)
        ##1 (state_r == ST_DEEP_SLEEP) |=> !slowRdy_r)
        else $error("slow ready high in deep sleep");
    chk_fast_ready_time: assert property (
        $rose(fastOscEnable) |-> !fastRdy_r ##16 (fastRdy_r || !fastEn_r))
        else $error("fast ready not set after 16 cycles");
    chk_reserved_zero: assert property (
        (regRd && regAddr == `SCMC_ADDR_CTRL) |=> regRdata[6:4] == 3'b000)
        else $error("reserved control bits not zero");
    chk_flag_set_wins: assert property (
        (watchdogCtrlReset && clrWrf) |=> wrfFlag_r)
        else $error("watchdog flag lost to clear");

endmodule : scmc_clock_mode_ctrl

// *** hdl/scmc_defs.svh ***
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCMC_ADDR_MODE 3'h0
`define SCMC_ADDR_CTRL 3'h1
`define SCMC_ADDR_SUBSEL 3'h2
`define SCMC_ADDR_STAT 3'h3
`define SCMC_ADDR_MASK 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCMC_MODE_FASTSEL 0
`define SCMC_MODE_IDLESEL 1
`define SCMC_MODE_FASTRDY 2
`define SCMC_MODE_SLOWRDY 3
`define SCMC_MODE_DIV_LO 5
`define SCMC_CTRL_WDT 0
`define SCMC_CTRL_LRF 1
`define SCMC_CTRL_BOR 2
`define SCMC_CTRL_SUBF 3
`define SCMC_CTRL_KEEP 7
`define SCMC_SUB_LOWPWR 7

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SCMC_MODE_RST 8'h03
`define SCMC_SUB_RST 8'h2a
`define SCMC_SUB_RC 7'h2a
`define SCMC_SUB_XTAL 7'h55

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SCMC_FAST_READY_CYCLES 16
`define SCMC_SLOW_XTAL_TICKS 1024
`define SCMC_SLOW_RC_TICKS 2

`endif

// *** hdl/scmc_pkg.sv ***
package scmc_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DEEP_SLEEP,
        ST_LIGHT_SLEEP,
        ST_IDLE_STOPPED,
        ST_IDLE_RUNNING
    } scmc_mode_e;

endpackage : scmc_pkg

// *** testbench/scmc_cpu_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// CPU core and subclock source
// ----------------------------------------
module scmc_cpu_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic subclkEnable,
    input wire logic haltCmd,
    input wire logic wakeCmd,
    output logic haltReq = 1'b0,
    output logic wakeReq = 1'b0,
    output logic subTick = 1'b0
);
    logic [2:0] subCnt_r = 3'h0;

    always @(posedge sys_clk) begin
        haltReq <= haltCmd && !rst;
        wakeReq <= wakeCmd && !rst;
        // Oscillator stops and its count clears to zero while disabled
        subCnt_r <= (rst || !subclkEnable) ? 3'h0 : subCnt_r + 3'h1;
        subTick <= subclkEnable && !rst && subCnt_r == 3'h7;
    end
endmodule : scmc_cpu_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "scmc_defs.svh"
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0, regRd = 1'b0, haltCmd = 1'b0, wakeCmd = 1'b0;
    logic voltageDetectEnable = 1'b0, watchdogEnable = 1'b0;
    logic lowVoltageEvent = 1'b0, brownoutLevelBad = 1'b0;
    logic watchdogCtrlReset = 1'b0;
    logic [7:0] regRdata;
    logic haltReq, wakeReq, subTick, sysClkTick, cpuRun, fastOscEnable;
    logic subclkEnable, slowSrcCrystal, slowLowPower, watchdogRun;
    logic detectorKeep, periphEnable, subcodeResetReq, brownoutSwReset, irq;
    int numErrors = 0, nChecks = 0, cycleCount = 0, ticks;

    always #25 sys_clk = ~sys_clk;

    scmc_cpu_model u_cpu (.sys_clk(sys_clk), .rst(rst),
        .subclkEnable(subclkEnable), .haltCmd(haltCmd), .wakeCmd(wakeCmd),
        .haltReq(haltReq), .wakeReq(wakeReq), .subTick(subTick));

    scmc_clock_mode_ctrl u_dut (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .haltReq(haltReq),
        .wakeReq(wakeReq), .subTick(subTick),
        .voltageDetectEnable(voltageDetectEnable),
        .watchdogEnable(watchdogEnable), .lowVoltageEvent(lowVoltageEvent),
        .brownoutLevelBad(brownoutLevelBad),
        .watchdogCtrlReset(watchdogCtrlReset), .sysClkTick(sysClkTick),
        .cpuRun(cpuRun), .fastOscEnable(fastOscEnable),
        .subclkEnable(subclkEnable), .slowSrcCrystal(slowSrcCrystal),
        .slowLowPower(slowLowPower), .watchdogRun(watchdogRun),
        .detectorKeep(detectorKeep), .periphEnable(periphEnable),
        .subcodeResetReq(subcodeResetReq),
        .brownoutSwReset(brownoutSwReset), .irq(irq));

    // ----------------------------------------
    // Checks and bus access
    // ----------------------------------------
    task automatic finishTest();
        if (numErrors == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finishTest

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic chkCnt(input int got, input int exp);
        nChecks++;
        if (got != exp) begin
            numErrors++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chkCnt

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rdChk(input logic [2:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk8(regRdata & m, exp);
    endtask : rdChk

    task automatic halt();
        @(posedge sys_clk);
        haltCmd <= 1'b1;
        @(posedge sys_clk);
        haltCmd <= 1'b0;
        cyc(4);
    endtask : halt

    task automatic wake();
        @(posedge sys_clk);
        wakeCmd <= 1'b1;
        @(posedge sys_clk);
        wakeCmd <= 1'b0;
        cyc(3);
    endtask : wake

    // Cfg is idle select, keep, detector, watchdog
    task automatic runMode(input logic [3:0] cfg, input logic [5:0] exp,
                           input logic [5:0] care, input logic [7:0] rdy);
        wr(`SCMC_ADDR_MODE, {6'h00, cfg[3], 1'b1});
        wr(`SCMC_ADDR_CTRL, {cfg[2], 7'h00});
        @(posedge sys_clk);
        voltageDetectEnable <= cfg[1];
        watchdogEnable <= cfg[0];
        cyc(3);
        halt();
        chk8({2'h0, {cpuRun, subclkEnable, fastOscEnable, periphEnable,
              watchdogRun, detectorKeep} & care}, {2'h0, exp & care});
        rdChk(`SCMC_ADDR_MODE, 8'h0c, rdy);
        wake();
        chk1(cpuRun, 1'b1);
        if (rdy[2] === 1'b0) begin
            rdChk(`SCMC_ADDR_MODE, 8'h04, 8'h00);
        end
        cyc(30);
        rdChk(`SCMC_ADDR_MODE, 8'h0c, 8'h0c);
        @(posedge sys_clk);
        voltageDetectEnable <= 1'b0;
        watchdogEnable <= 1'b0;
    endtask : runMode

    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == 30000) begin
            numErrors++;
            finishTest();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(40);
        rdChk(`SCMC_ADDR_MODE, 8'hff, 8'h0f);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h00);
        rdChk(`SCMC_ADDR_SUBSEL, 8'hff, 8'h2a);
        rdChk(`SCMC_ADDR_STAT, 8'hff, 8'h03);
        wr(`SCMC_ADDR_STAT, 8'h03);
        rdChk(`SCMC_ADDR_STAT, 8'hff, 8'h00);
        wr(3'h5, 8'hff);
        rdChk(3'h5, 8'hff, 8'h00);
        wr(`SCMC_ADDR_MODE, 8'h13);
        rdChk(`SCMC_ADDR_MODE, 8'hff, 8'h0f);
        wr(`SCMC_ADDR_CTRL, 8'hf0);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h80);
        wr(`SCMC_ADDR_MASK, 8'h08);
        rdChk(`SCMC_ADDR_MASK, 8'hff, 8'h08);
        @(posedge sys_clk);
        lowVoltageEvent <= 1'b1;
        watchdogCtrlReset <= 1'b1;
        brownoutLevelBad <= 1'b1;
        @(posedge sys_clk);
        lowVoltageEvent <= 1'b0;
        watchdogCtrlReset <= 1'b0;
        cyc(2);
        chk1(brownoutSwReset, 1'b1);
        chk1(irq, 1'b1);
        @(posedge sys_clk);
        brownoutLevelBad <= 1'b0;
        cyc(2);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h87);
        wr(`SCMC_ADDR_CTRL, 8'h05);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h05);
        wr(`SCMC_ADDR_CTRL, 8'h00);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h00);
        fork
            wr(`SCMC_ADDR_CTRL, 8'h00);
            begin
                @(posedge sys_clk);
                watchdogCtrlReset <= 1'b1;
                @(posedge sys_clk);
                watchdogCtrlReset <= 1'b0;
            end
        join
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h01);
        wr(`SCMC_ADDR_CTRL, 8'h00);
        wr(`SCMC_ADDR_MASK, 8'h00);
        cyc(2);
        chk1(irq, 1'b0);
        wr(`SCMC_ADDR_STAT, 8'h0f);
        rdChk(`SCMC_ADDR_STAT, 8'hff, 8'h00);
        wr(`SCMC_ADDR_SUBSEL, 8'h11);
        cyc(2);
        chk1(subcodeResetReq, 1'b1);
        wr(`SCMC_ADDR_SUBSEL, 8'hd5);
        cyc(2);
        chk1(subcodeResetReq, 1'b0);
        chk1(slowSrcCrystal, 1'b1);
        chk1(slowLowPower, 1'b1);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h08);
        wr(`SCMC_ADDR_CTRL, 8'h00);
        rdChk(`SCMC_ADDR_CTRL, 8'hff, 8'h00);
        wr(`SCMC_ADDR_SUBSEL, 8'h2a);
        cyc(2);
        chk1(slowSrcCrystal, 1'b0);
        for (int i = 0; i < 9; i++) begin
            wr(`SCMC_ADDR_MODE, i == 8 ? 8'h03 : {i[2:0], 5'h02});
            cyc(200);
            ticks = 0;
            repeat (256) begin
                @(posedge sys_clk);
                #1;
                if (sysClkTick === 1'b1) ticks++;
            end
            chkCnt(ticks, i < 2 ? 32 : 256 >> (8 - i));
            if (i < 2) chk1(fastOscEnable, 1'b0);
        end
        runMode(4'b0000, 6'h00, 6'h3f, 8'h00);
        runMode(4'b0010, 6'h11, 6'h3f, 8'h08);
        runMode(4'b0001, 6'h12, 6'h3f, 8'h08);
        runMode(4'b1000, 6'h10, 6'h3b, 8'h08);
        runMode(4'b1110, 6'h19, 6'h3b, 8'h0c);
        wr(`SCMC_ADDR_SUBSEL, 8'h55);
        wr(`SCMC_ADDR_MODE, 8'h01);
        cyc(300);
        halt();
        chk1(subclkEnable, 1'b0);
        wake();
        cyc(7800);
        rdChk(`SCMC_ADDR_MODE, 8'h08, 8'h00);
        cyc(800);
        rdChk(`SCMC_ADDR_MODE, 8'h08, 8'h08);
        finishTest();
    end
endmodule : tb
